// ===== verilog/hsctl_core.sv
// Purpose: Hot-swap state control of regulation, fault, latch-off and restart with enable gating.
// Assumes: Analog comparator results and fault inputs arrive synchronous to clk_sys.
// Notes:   Registers sit on Avalon-MM; every access answers one cycle after it is raised.
//
// Overview of operation
// R1 - Current regulation starts delay timer on overcurrent.
// R2 - Persisting condition starts regulation timer, lowers gate.
// R3 - Fault state idles until cleared or cool-down ends.
// R4 - Exhausted retries go straight to latch-off.
// R5 - Latch-off holds until faults clear and restart.
// R6 - Memory error enters fault, then permanent memory lockout.
// R7 - Restart command waits ten seconds, switch off.
// R8 - Registers always reachable; pin or command gates switch.
// R9 - Starts automatically unless operation bit disables it.
// R10 - Digital mode deglitches every enable pin transition.
// R11 - Enable low turns off; status bits kept.
// R12 - Deglitch value zero lets host time enable.
// R13 - Analog mode debounce runs once after reset.
// R14 - Mode selects enable or undervoltage pin role.
// R15 - Undervoltage role: low runs undervoltage fault procedure.
// R16 - Enable role: on and off without fault procedure.
// R17 - Enable high lets operation bit decide switch.
// R18 - Enable falling edge clears faults except memory.
// R19 - Connector present low only permits switch on.
// R20 - Switch active only with operation, enable, connector.
// R21 - Standby checks input voltage range before start.
// R22 - Startup ends when drain-source low, gate high.
// R23 - Four-bit state code; synchronised enable and connector.
//
// The Avalon-MM slave port and the register offsets were chosen for this implementation.
module hsctl_core
  import hsctl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES        = TICK_CYCLES_DFLT,
  parameter int unsigned RESTART_WAIT_TICKS = RESTART_WAIT_TICKS_DFLT
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        undervolt_enable_pin,
  input  wire logic        connector_present_n,
  input  wire logic        vin_in_range,
  input  wire logic        overcurrent_in,
  input  wire logic        soa_violation_in,
  input  wire logic        vds_low_in,
  input  wire logic        vgs_high_in,
  input  wire logic        switch_short_in,
  input  wire logic        retry_fault_in,
  input  wire logic        nonretry_fault_in,
  input  wire logic        mem_error_in,
  output logic             gate_enable,
  output logic             gate_regulate,
  output logic [3:0]       state_code
);

  hsctl_core_t q;
  hsctl_core_t n;
  logic        en_level;
  logic        en_fall;
  logic        en_mode;
  logic        permit;
  logic        over;
  logic        active;
  logic        wr_now;
  logic        restart_cmd;
  logic [31:0] wimg;
  logic [3:0]  flt_set;
  logic [3:0]  flt_clr;
  logic [15:0] cnt_inc;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] read_word(input logic [3:0] addr, input hsctl_core_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (addr)
      ADDR_CTRL: begin
        w[CTRL_OP_ON]          = s.op_on;
        w[CTRL_FULL_DIG]       = s.full_digital;
        w[CTRL_DIG_CMP]        = s.digital_cmp;
        w[CTRL_DG_LSB +: 4]    = s.dg_limit;
      end
      ADDR_TIMING: begin
        w[TIM_DELAY_LSB +: 8]  = s.delay_limit;
        w[TIM_REG_LSB +: 8]    = s.reg_limit;
        w[TIM_COOL_LSB +: 8]   = s.cooldown;
        w[TIM_RETRY_LSB +: 3]  = s.retry_limit;
      end
      ADDR_STATUS: begin
        w[STAT_STATE_LSB +: 4] = s.state;
        w[STAT_GATE]           = s.gate_enable;
        w[STAT_REGULATE]       = s.gate_regulate;
        w[STAT_ENABLE]         = s.pin_s2;
        w[STAT_CONN_N]         = s.conn_s2;
        w[STAT_FLT_LSB +: 4]   = s.fault_flags;
        w[STAT_RETRY_LSB +: 3] = s.retry_cnt;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic is_active(input hsctl_state_t s);
    is_active = (s == startup_regulation_state) || (s == on_state) || (s == current_reg_state);
  endfunction

  hsctl_deglitch u_deglitch (
    .clk_sys      (clk_sys),
    .rst_b        (rst_b),
    .ce           (ce),
    .tick         (q.tick),
    .pin_sync     (q.pin_s2),
    .digital_mode (en_mode),
    .dg_limit     (q.dg_limit),
    .en_level     (en_level),
    .en_fall      (en_fall)
  );

  always_comb begin
    n         = q;
    flt_set   = 4'h0;
    flt_clr   = 4'h0;
    wimg      = 32'h0000_0000;
    cnt_inc   = q.cnt + 16'h0001;
    en_mode   = q.full_digital & q.digital_cmp; // see R14
    // The op bit, pin and connector jointly permit the switch.
    permit    = q.op_on & en_level & ~q.conn_s2; // see R17 see R19 see R20
    over      = overcurrent_in | soa_violation_in;
    active    = is_active(q.state);
    wr_now    = avs_write & ~q.waitreq;
    restart_cmd = wr_now && (avs_address == ADDR_CTRL) && avs_byteenable[1]
                  && avs_writedata[CTRL_RESTART];

    n.pin_s1  = undervolt_enable_pin; // see R23
    n.pin_s2  = q.pin_s1;
    n.conn_s1 = connector_present_n;
    n.conn_s2 = q.conn_s1;

    n.tick     = (q.tick_cnt == 32'(TICK_CYCLES - 1));
    n.tick_cnt = n.tick ? 32'h0000_0000 : q.tick_cnt + 32'h0000_0001;

    // The bus runs in every state so software can always reprogram the block.
    if (q.waitreq) begin
      if (avs_read | avs_write) begin
        n.waitreq  = 1'b0; // see R8
        n.readdata = avs_read ? read_word(avs_address, q) : 32'h0000_0000;
      end
    end else begin
      n.waitreq = 1'b1;
    end
    if (wr_now) begin
      wimg = (read_word(avs_address, q) & ~lane_mask(avs_byteenable))
             | (avs_writedata & lane_mask(avs_byteenable));
      unique case (avs_address)
        ADDR_CTRL: begin
          n.op_on        = wimg[CTRL_OP_ON]; // see R9
          n.full_digital = wimg[CTRL_FULL_DIG];
          n.digital_cmp  = wimg[CTRL_DIG_CMP];
          n.dg_limit     = wimg[CTRL_DG_LSB +: 4];
        end
        ADDR_TIMING: begin
          n.delay_limit  = wimg[TIM_DELAY_LSB +: 8];
          n.reg_limit    = wimg[TIM_REG_LSB +: 8];
          n.cooldown     = wimg[TIM_COOL_LSB +: 8];
          n.retry_limit  = wimg[TIM_RETRY_LSB +: 3];
        end
        ADDR_STATUS: flt_clr = wimg[STAT_FLT_LSB +: 4] & avs_writedata[STAT_FLT_LSB +: 4];
        default: ;
      endcase
    end

    if (mem_error_in && (q.state != mem_fault_state)) begin
      n.state = fault_state; // see R6
      flt_set[FLT_MEM] = 1'b1;
    end else if (active) begin
      if (!permit) begin
        if (!en_mode && !en_level && q.op_on && !q.conn_s2) begin
          n.state = fault_state; // see R15
          n.retry_kind = 1'b0;
          flt_set[FLT_NONRETRY] = 1'b1;
        end else begin
          n.state = standby_state; // see R11 see R16 see R20
        end
      end else if (restart_cmd) begin
        n.state = restart_wait_state; // see R7
      end else if (retry_fault_in) begin
        n.state = fault_state;
        n.retry_kind = 1'b1;
        flt_set[FLT_RETRY] = 1'b1;
      end else if (nonretry_fault_in) begin
        n.state = fault_state;
        n.retry_kind = 1'b0;
        flt_set[FLT_NONRETRY] = 1'b1;
      end else begin
        unique case (q.state)
          startup_regulation_state: begin
            if (vds_low_in && vgs_high_in) begin
              n.state = on_state; // see R22
            end
          end
          on_state: begin
            n.retry_cnt = 3'h0;
            if (over) begin
              n.state = current_reg_state; // see R1
            end
          end
          default: begin
            if (!over) begin
              n.state = on_state;
            end else if (q.tick) begin
              if (!q.reg_phase) begin
                if (cnt_inc >= {8'h00, q.delay_limit}) begin
                  n.reg_phase = 1'b1; // see R2
                  n.cnt = 16'h0000;
                end else begin
                  n.cnt = cnt_inc; // see R1
                end
              end else if (cnt_inc >= {8'h00, q.reg_limit}) begin
                n.state = fault_state;
                n.retry_kind = 1'b1;
                flt_set[FLT_RETRY] = 1'b1;
              end else begin
                n.cnt = cnt_inc;
              end
            end
          end
        endcase
      end
    end else begin
      unique case (q.state)
        por_init_state: n.state = read_cfg_state;
        read_cfg_state: n.state = switch_check_state;
        switch_check_state: begin
          if (switch_short_in) begin
            n.state = fault_state;
            n.retry_kind = 1'b0;
            flt_set[FLT_NONRETRY] = 1'b1;
          end else begin
            n.state = standby_state;
          end
        end
        standby_state: begin
          if (restart_cmd) begin
            n.state = restart_wait_state; // see R7
          end else if (permit) begin
            if (!vin_in_range) begin
              n.state = fault_state; // see R21
              n.retry_kind = 1'b0;
              flt_set[FLT_VIN] = 1'b1;
            end else begin
              n.state = startup_regulation_state; // see R9
            end
          end
        end
        fault_state: begin
          if (q.fault_flags[FLT_MEM]) begin
            n.state = mem_fault_state; // see R6
          end else if (en_mode && en_fall) begin
            n.state = switch_check_state; // see R18
            n.retry_cnt = 3'h0;
          end else if (q.retry_kind) begin
            if (q.retry_cnt >= q.retry_limit) begin
              n.state = latch_off_state; // see R4
            end else if (q.tick) begin
              if (cnt_inc >= {8'h00, q.cooldown}) begin
                n.state = switch_check_state; // see R3
                n.retry_cnt = q.retry_cnt + 3'h1;
              end else begin
                n.cnt = cnt_inc;
              end
            end
          end else if (!nonretry_fault_in && vin_in_range && (en_mode || en_level)) begin
            n.state = standby_state; // see R3
          end
        end
        latch_off_state: begin
          if (en_mode && en_fall) begin
            n.state = switch_check_state; // see R18
            n.retry_cnt = 3'h0;
          end else if (restart_cmd && !retry_fault_in && !nonretry_fault_in) begin
            n.state = switch_check_state; // see R5
            n.retry_cnt = 3'h0;
          end
        end
        mem_fault_state: n.state = mem_fault_state; // see R6
        restart_wait_state: begin
          if (q.tick) begin
            if (cnt_inc >= 16'(RESTART_WAIT_TICKS)) begin
              n.state = standby_state; // see R7
            end else begin
              n.cnt = cnt_inc;
            end
          end
        end
        default: n.state = por_init_state;
      endcase
    end

    if (n.state != q.state) begin
      n.cnt       = 16'h0000;
      n.reg_phase = 1'b0;
    end
    if (en_mode && en_fall) begin
      flt_clr = flt_clr | 4'h7; // see R18
    end
    // Hardware sets win over clears so no event is lost.
    n.fault_flags   = (q.fault_flags & ~flt_clr) | flt_set; // see R11
    n.gate_enable   = is_active(n.state); // see R20
    n.gate_regulate = (n.state == startup_regulation_state)
                      || ((n.state == current_reg_state) && n.reg_phase); // see R2
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q              <= '0;
      q.state        <= por_init_state;
      q.op_on        <= RST_OP_ON;
      q.full_digital <= RST_FULL_DIG;
      q.digital_cmp  <= RST_DIG_CMP;
      q.dg_limit     <= RST_DG_LIMIT;
      q.delay_limit  <= RST_DELAY_LIMIT;
      q.reg_limit    <= RST_REG_LIMIT;
      q.cooldown     <= RST_COOLDOWN;
      q.retry_limit  <= RST_RETRY_LIMIT;
      q.waitreq      <= 1'b1;
    end else if (ce) begin
      q <= n;
    end
  end

  assign avs_readdata    = q.readdata;
  assign avs_waitrequest = q.waitreq;
  assign gate_enable     = q.gate_enable;
  assign gate_regulate   = q.gate_regulate;
  assign state_code      = q.state; // see R23

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence s_calm;
    ce && !mem_error_in && !restart_cmd && !retry_fault_in && !nonretry_fault_in;
  endsequence
  sequence s_start_ok;
    s_calm ##0 (q.state == startup_regulation_state) && permit && vds_low_in && vgs_high_in;
  endsequence
  sequence s_mem_hit;
    ce && mem_error_in && (q.state != mem_fault_state);
  endsequence

  property p_ireg_entry;
    s_calm ##0 (q.state == on_state) && permit && over |=> (q.state == current_reg_state);
  endproperty
  a_ireg_entry: assert property (p_ireg_entry) else $error("no current regulation"); // see R1

  property p_regulate;
    gate_regulate |-> (q.state == startup_regulation_state)
                      || ((q.state == current_reg_state) && q.reg_phase);
  endproperty
  a_regulate: assert property (p_regulate) else $error("regulate out of state"); // see R2

  property p_retry_out;
    ce && !mem_error_in && !en_fall && (q.state == fault_state) && !q.fault_flags[FLT_MEM]
    && q.retry_kind && (q.retry_cnt >= q.retry_limit) |=> (q.state == latch_off_state);
  endproperty
  a_retry_out: assert property (p_retry_out) else $error("retries not latched"); // see R4

  property p_latch_hold;
    ce && !mem_error_in && !restart_cmd && !en_fall && (q.state == latch_off_state)
    |=> (q.state == latch_off_state) && !gate_enable;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch-off left"); // see R5

  property p_mem_lock;
    s_mem_hit |=> (q.state == fault_state) ##1 (q.state != on_state);
  endproperty
  a_mem_lock: assert property (p_mem_lock) else $error("memory error missed"); // see R6

  property p_mem_stay;
    (q.state == mem_fault_state) |=> (q.state == mem_fault_state) && !gate_enable;
  endproperty
  a_mem_stay: assert property (p_mem_stay) else $error("memory lockout left"); // see R6

  property p_wait_off;
    (q.state == restart_wait_state) |-> !gate_enable && (q.cnt < 16'(RESTART_WAIT_TICKS));
  endproperty
  a_wait_off: assert property (p_wait_off) else $error("switch on in restart wait"); // see R7

  property p_en_fall;
    ce && !mem_error_in && en_mode && en_fall && (q.state == latch_off_state)
    |=> (q.state == switch_check_state) && (q.fault_flags[FLT_RETRY] == 1'b0);
  endproperty
  a_en_fall: assert property (p_en_fall) else $error("enable fall kept faults"); // see R18

  property p_conn_block;
    ce && q.conn_s2 && (q.state == standby_state) |=> (q.state != startup_regulation_state);
  endproperty
  a_conn_block: assert property (p_conn_block) else $error("start with connector open"); // see R19

  property p_no_permit;
    ce && active && !permit |=> !gate_enable;
  endproperty
  a_no_permit: assert property (p_no_permit) else $error("switch on without permit"); // see R20

  property p_vin_check;
    s_calm ##0 (q.state == standby_state) && permit && !vin_in_range |=> (q.state == fault_state);
  endproperty
  a_vin_check: assert property (p_vin_check) else $error("start outside input range"); // see R21

  property p_start_done;
    s_start_ok |=> (q.state == on_state) && gate_enable && !gate_regulate;
  endproperty
  a_start_done: assert property (p_start_done) else $error("startup did not end"); // see R22

endmodule : hsctl_core

// ===== verilog/hsctl_pkg.sv
// Purpose: Shared constants, state encoding and state records of the hot-swap state control.
// Assumes: 50 MHz system clock; register offsets are byte addresses on Avalon-MM.
// Notes:   The deglitch and state timers count in ticks of one millisecond.
package hsctl_pkg;

  localparam int CLK_HZ                  = 50_000_000;
  localparam int TICK_US                 = 1000;
  localparam int TICK_CYCLES_DFLT        = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int RESTART_WAIT_S          = 10;
  localparam int RESTART_WAIT_TICKS_DFLT = (RESTART_WAIT_S * 1_000_000) / TICK_US;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_TIMING = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  localparam int CTRL_OP_ON     = 0;
  localparam int CTRL_FULL_DIG  = 1;
  localparam int CTRL_DIG_CMP   = 2;
  localparam int CTRL_DG_LSB    = 4;
  localparam int CTRL_RESTART   = 8;
  localparam int TIM_DELAY_LSB  = 0;
  localparam int TIM_REG_LSB    = 8;
  localparam int TIM_COOL_LSB   = 16;
  localparam int TIM_RETRY_LSB  = 24;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_GATE      = 4;
  localparam int STAT_REGULATE  = 5;
  localparam int STAT_ENABLE    = 6;
  localparam int STAT_CONN_N    = 7;
  localparam int STAT_FLT_LSB   = 8;
  localparam int STAT_RETRY_LSB = 12;

  localparam int FLT_RETRY    = 0;
  localparam int FLT_NONRETRY = 1;
  localparam int FLT_VIN      = 2;
  localparam int FLT_MEM      = 3;

  localparam logic       RST_OP_ON       = 1'b1;
  localparam logic       RST_FULL_DIG    = 1'b1;
  localparam logic       RST_DIG_CMP     = 1'b1;
  localparam logic [3:0] RST_DG_LIMIT    = 4'h1;
  localparam logic [7:0] RST_DELAY_LIMIT = 8'h0a;
  localparam logic [7:0] RST_REG_LIMIT   = 8'h32;
  localparam logic [7:0] RST_COOLDOWN    = 8'h64;
  localparam logic [2:0] RST_RETRY_LIMIT = 3'h3;

  typedef enum logic [3:0] {
    por_init_state,
    read_cfg_state,
    switch_check_state,
    standby_state,
    startup_regulation_state,
    on_state,
    current_reg_state,
    fault_state,
    latch_off_state,
    mem_fault_state,
    restart_wait_state
  } hsctl_state_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       level;
    logic       busy;
    logic       acm_done;
    logic       fall;
  } hsctl_dg_t;

  typedef struct packed {
    logic         pin_s1;
    logic         pin_s2;
    logic         conn_s1;
    logic         conn_s2;
    hsctl_state_t state;
    logic [15:0]  cnt;
    logic         reg_phase;
    logic         retry_kind;
    logic [2:0]   retry_cnt;
    logic [3:0]   fault_flags;
    logic         op_on;
    logic         full_digital;
    logic         digital_cmp;
    logic [3:0]   dg_limit;
    logic [7:0]   delay_limit;
    logic [7:0]   reg_limit;
    logic [7:0]   cooldown;
    logic [2:0]   retry_limit;
    logic [31:0]  tick_cnt;
    logic         tick;
    logic         waitreq;
    logic [31:0]  readdata;
    logic         gate_enable;
    logic         gate_regulate;
  } hsctl_core_t;

endpackage : hsctl_pkg

// ===== verilog/hsctl_deglitch.sv
// Purpose: Enable deglitch timer for the combined undervoltage/enable pin.
// Assumes: pin_sync is already synchronised; tick is a one-cycle pulse per timer unit.
// Notes:   In analog compare mode the timer runs once after reset and then the pin passes through.
module hsctl_deglitch
  import hsctl_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic       tick,
  input  wire logic       pin_sync,
  input  wire logic       digital_mode,
  input  wire logic [3:0] dg_limit,
  output logic            en_level,
  output logic            en_fall
);

  hsctl_dg_t q;
  hsctl_dg_t n;

  always_comb begin
    n      = q;
    n.fall = 1'b0;
    if (digital_mode) begin
      if (pin_sync != q.level) begin
        if (dg_limit == 4'h0) begin
          n.level = pin_sync; // see R12
          n.fall  = q.level & ~pin_sync;
          n.busy  = 1'b0;
        end else if (!q.busy) begin
          n.busy = 1'b1; // see R10
          n.cnt  = 4'h0;
        end else if (tick) begin
          if (q.cnt + 4'h1 >= dg_limit) begin
            n.level = pin_sync; // see R10
            n.fall  = q.level & ~pin_sync;
            n.busy  = 1'b0;
          end else begin
            n.cnt = q.cnt + 4'h1;
          end
        end
      end else begin
        // A pin that returns before expiry cancels the pending change.
        n.busy = 1'b0;
      end
    end else begin
      if (!q.acm_done) begin
        if (q.cnt >= dg_limit) begin
          n.acm_done = 1'b1; // see R13
        end else if (tick) begin
          n.cnt = q.cnt + 4'h1;
        end
        n.level = 1'b0;
      end else begin
        n.level = pin_sync; // see R13
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  assign en_level = q.level;
  assign en_fall  = q.fall;

endmodule : hsctl_deglitch

// ===== verif/hsctl_switch_model.sv
// Purpose: Model of the external switch as the gate drive sees it.
// Assumes: The output settles a fixed few cycles after the gate is driven.
// Notes:   Both status lines drop at once on release, so stale levels never linger.
module hsctl_switch_model (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic gate_enable,
  output logic      vds_low_in,
  output logic      vgs_high_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_reg;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= 3'h0;
    end else if (!gate_enable) begin
      cnt_reg <= 3'h0;
    end else if (cnt_reg != 3'h6) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
  assign vds_low_in  = (cnt_reg == 3'h6);
  assign vgs_high_in = (cnt_reg == 3'h6);
endmodule // hsctl_switch_model

// ===== verif/hsctl_core_tb.sv
// Purpose: Self-checking bench of the hot-swap state control.
// Assumes: Short tick and restart counts; one bus access at a time.
// Notes:   Waits are bounded, so a stuck state shows as a mismatch, not a hang.
module hsctl_core_tb;
  import hsctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_b = 1'b0, pin = 1'b1, conn_n = 1'b0, vin = 1'b0;
  logic oc = 1'b0, rflt = 1'b0, mem = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic ce = 1'b1, soa = 1'b0, nflt = 1'b0;
  logic [3:0]  avs_address = 4'h0, state_code;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic        avs_waitrequest, gate_enable, gate_regulate, vds_low, vgs_high;
  int          mismatches = 0, tests_run = 0, cyc;
  always #10 clk_sys = ~clk_sys;
  hsctl_core #(.TICK_CYCLES(4), .RESTART_WAIT_TICKS(5)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .undervolt_enable_pin(pin), .connector_present_n(conn_n), .vin_in_range(vin),
    .overcurrent_in(oc), .soa_violation_in(soa), .vds_low_in(vds_low),
    .vgs_high_in(vgs_high), .switch_short_in(1'b0), .retry_fault_in(rflt),
    .nonretry_fault_in(nflt), .mem_error_in(mem), .gate_enable(gate_enable),
    .gate_regulate(gate_regulate), .state_code(state_code));
  hsctl_switch_model sw (.clk_sys(clk_sys), .rst_b(rst_b), .gate_enable(gate_enable),
    .vds_low_in(vds_low), .vgs_high_in(vgs_high));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // The request is held until waitrequest is sampled low at a rising edge, then released there.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) begin
      mismatches++;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_st(input logic [3:0] s);
    cyc = 0;
    while (state_code !== s && cyc < 3000) begin
      @(posedge clk_sys);
      cyc++;
    end
    check("state_code", {28'h0, state_code}, {28'h0, s});
  endtask
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    check("state_code", {28'h0, state_code}, 32'h0);
    bus(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl", rd, {24'h0, RST_DG_LIMIT, 1'b0, RST_DIG_CMP, RST_FULL_DIG, RST_OP_ON});
    bus(1'b0, ADDR_TIMING, 32'h0);
    check("timing", rd, {5'h0, RST_RETRY_LIMIT, RST_COOLDOWN, RST_REG_LIMIT, RST_DELAY_LIMIT});
    bus(1'b0, 4'hc, 32'h0);
    check("unmapped", rd, 32'h0);
    wait_st(4'd7);
    check("gate", {31'h0, gate_enable}, 32'h0);
    vin <= 1'b1;
    wait_st(4'd4);
    check("gate", {30'h0, gate_enable, gate_regulate}, 32'h3);
    wait_st(4'd5);
    check("regulate", {31'h0, gate_regulate}, 32'h0);
    // Retry limit 0 makes the first retry fault latch off.
    bus(1'b1, ADDR_TIMING, 32'h00020202);
    soa <= 1'b1;
    wait_st(4'd6);
    soa <= 1'b0;
    wait_st(4'd5);
    oc <= 1'b1;
    wait_st(4'd6);
    check("regulate", {31'h0, gate_regulate}, 32'h0);
    @(posedge gate_regulate);
    @(posedge clk_sys);
    check("state_code", {28'h0, state_code}, 32'h6);
    wait_st(4'd8);
    oc <= 1'b0;
    check("gate", {31'h0, gate_enable}, 32'h0);
    pin <= 1'b0;
    wait_st(4'd3);
    check("gate", {31'h0, gate_enable}, 32'h0);
    pin <= 1'b1;
    wait_st(4'd5);
    rflt <= 1'b1;
    wait_st(4'd8);
    rflt <= 1'b0;
    bus(1'b1, ADDR_CTRL, 32'h00000117);
    wait_st(4'd5);
    bus(1'b1, ADDR_CTRL, 32'h00000117);
    wait_st(4'd10);
    check("gate", {31'h0, gate_enable}, 32'h0);
    wait_st(4'd3);
    check("wait", {31'h0, (cyc > 14 && cyc < 30)}, 32'h1);
    wait_st(4'd5);
    conn_n <= 1'b1;
    wait_st(4'd3);
    check("gate", {31'h0, gate_enable}, 32'h0);
    conn_n <= 1'b0;
    wait_st(4'd5);
    bus(1'b1, ADDR_CTRL, 32'h00000016);
    wait_st(4'd3);
    bus(1'b1, ADDR_CTRL, 32'h00000017);
    wait_st(4'd5);
    // With the clock enable low an open connector must not be noticed.
    ce <= 1'b0;
    conn_n <= 1'b1;
    repeat (10) @(posedge clk_sys);
    check("frozen", {28'h0, state_code}, 32'h5);
    conn_n <= 1'b0;
    ce <= 1'b1;
    nflt <= 1'b1;
    wait_st(4'd7);
    repeat (10) @(posedge clk_sys);
    check("nonretry_hold", {27'h0, state_code, gate_enable}, 32'he);
    nflt <= 1'b0;
    wait_st(4'd5);
    mem <= 1'b1;
    wait_st(4'd7);
    mem <= 1'b0;
    wait_st(4'd9);
    pin <= 1'b0;
    repeat (40) @(posedge clk_sys);
    check("state_code", {28'h0, state_code}, 32'h9);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status_state", {28'h0, rd[3:0]}, 32'h9);
    tally_and_finish;
  end
endmodule // hsctl_core_tb
